// >>> testbench.sv
// self-checking bench for the result bank
`timescale 1ns/100ps
module testbench;
	import trb_pkg::*;
	logic clk;
	logic rst;
	trb_result_t result_in;
	trb_read_req_t read_req;
	trb_read_rsp_t read_rsp;
	trb_read_rsp_t r;
	logic [22:0] d;
	int fails;
	int samples_checked;
	int cycles;
	trb_result_bank u_trb_result_bank (.clk(clk), .rst(rst),
		.result_in(result_in), .read_req(read_req), .read_rsp(read_rsp));
	trb_host_model host (.clk(clk), .read_req(read_req), .read_rsp(read_rsp));
	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			wrap_up();
		end
	end
	task automatic check(input logic [25:0] seen, want);
		samples_checked++;
		if (seen !== want)
		begin
			fails++;
			$display("[FAIL] %0t %h %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		rst = 1'b1;
		result_in = '0;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		// zero after reset; 0x11 and 0x19 miss
		for (int a = 17; a <= 25; a++)
		begin
			host.rd(8'(a), r);
			check(r, {1'b1, a > 17 && a < 25, 24'h0});
		end
		// fill and read each slot, then read all again
		for (int p = 0; p < 14; p++)
		begin
			d = 23'h7a5a50 + 23'(p % 7);
			if (p < 7)
			begin
				@(posedge clk);
				#1 result_in = {1'b1, 3'(p), d};
				@(posedge clk);
				#1 result_in = '0;
			end
			host.rd(8'h12 + 8'(p % 7), r);
			if (p % 7 % 2)
				d[22:16] = 7'h00;
			check(r, {2'b11, ^d, d});
		end
		// mid-run reset clears every written word
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		for (int a = 18; a <= 24; a++)
		begin
			host.rd(8'(a), r);
			check(r, {2'b11, 24'h0});
		end
		// write and read of one slot on one edge: old word returned
		fork
			host.rd(8'h12, r);
			begin
				@(posedge clk);
				#1 result_in = {1'b1, 3'h0, d};
				@(posedge clk);
				#1 result_in = '0;
			end
		join
		check(r, {2'b11, 24'h0});
		host.rd(8'h12, r);
		check(r, {2'b11, ^d, d});
		wrap_up();
	end
endmodule

// >>> trb_host_model.sv
// host model issuing register reads
`timescale 1ns/100ps
module trb_host_model
	import trb_pkg::*;
(
	input wire logic clk, // clock
	output trb_pkg::trb_read_req_t read_req, // read
	input trb_pkg::trb_read_rsp_t read_rsp // answer
);
	initial read_req = '0;
	// one read; answer taken once the strobe edge has landed
	task automatic rd(input logic [7:0] a, output trb_read_rsp_t q);
		@(posedge clk);
		#1 read_req = {1'b1, a};
		@(posedge clk);
		#1 read_req = '0;
		q = read_rsp;
	endtask
endmodule

// >>> trb_pkg.sv
// package of offsets, field layouts and carrier types for the result bank
package trb_pkg;
	localparam int trb_addr_w = 8;
	localparam int trb_word_w = 24;
	localparam int trb_time_w = 23;
	localparam int trb_tally_w = 16;
	localparam int trb_parity_pos = 23;
	localparam int trb_tally_hi = 22;
	localparam int trb_tally_lo = 16;
	localparam int trb_slots = 7;
	localparam logic [7:0] trb_first_addr = 8'h12;
	localparam logic [7:0] trb_stop_interval_two = 8'h12;
	localparam logic [7:0] trb_coarse_tally_two = 8'h13;
	localparam logic [7:0] trb_stop_interval_three = 8'h14;
	localparam logic [7:0] trb_coarse_tally_three = 8'h15;
	localparam logic [7:0] trb_stop_interval_four = 8'h16;
	localparam logic [7:0] trb_coarse_tally_four = 8'h17;
	localparam logic [7:0] trb_stop_interval_five = 8'h18;
	localparam logic [23:0] trb_reset_word = 24'h000000;

	// one measurement result handed in by the measurement engine
	typedef struct packed {
		logic valid;
		logic [2:0] slot;
		logic [22:0] value;
	} trb_result_t;

	// host register read request and its answer
	typedef struct packed {
		logic rd;
		logic [7:0] addr;
	} trb_read_req_t;

	typedef struct packed {
		logic valid;
		logic hit;
		logic [23:0] data;
	} trb_read_rsp_t;
endpackage

// >>> trb_result_bank.sv
// read-only result bank: interval results for stops 2..5, coarse tallies for stops 2..4
// Functional notes
// RULE1: third-stop interval at 0x14, parity bit 23, 23-bit result, resets zero.
// RULE2: fourth-stop interval at 0x16, same layout, resets zero.
// RULE3: fifth-stop interval at 0x18, same layout, resets zero.
// RULE4: second coarse tally at 0x13, parity bit 23, count bits 15:0.
// RULE5: third coarse tally at 0x15, 16-bit count, parity top, resets zero.
// RULE6: fourth coarse tally at 0x17, 16-bit count, parity top, resets zero.
// RULE7: coarse tally bits 22:16 read zero in normal operation.
// RULE8: all fields read-only to host, zero after reset until measured.
// RULE9: second-stop interval at 0x12, interval layout, resets zero.
// RULE10: bit 23 is even parity over the lower data bits.
`timescale 1ns/100ps
module trb_result_bank
	import trb_pkg::*;
#(
	parameter int slots = trb_slots
) (
	input wire logic clk, // system clock, 100 MHz
	input wire logic rst, // synchronous reset, high
	input trb_pkg::trb_result_t result_in, // result from measurement engine
	input trb_pkg::trb_read_req_t read_req, // host register read
	output trb_pkg::trb_read_rsp_t read_rsp // read answer, one cycle later
);
	import trb_pkg::*;

	// decode below assumes this exact map; refuse anything else
	if (slots != trb_slots)
	begin
		$error("trb_result_bank supports exactly seven slots");
	end
	if (trb_word_w != trb_time_w + 1 || trb_parity_pos != trb_time_w)
	begin
		$error("trb_result_bank needs parity just above the result");
	end
	if (trb_tally_lo != trb_tally_w || trb_tally_hi != trb_time_w - 1)
	begin
		$error("trb_result_bank tally field layout mismatch");
	end
	if (trb_stop_interval_two != trb_first_addr
		|| trb_coarse_tally_two != trb_first_addr + 8'h01
		|| trb_stop_interval_three != trb_first_addr + 8'h02
		|| trb_coarse_tally_three != trb_first_addr + 8'h03
		|| trb_stop_interval_four != trb_first_addr + 8'h04
		|| trb_coarse_tally_four != trb_first_addr + 8'h05
		|| trb_stop_interval_five != trb_first_addr + 8'h06)
	begin
		$error("trb_result_bank address map is not contiguous");
	end

	logic [trb_slots-1:0] rd_sel; // host address hits this slot
	logic [trb_slots-1:0] wr_sel; // engine writes this slot
	logic [trb_slots-1:0] slot_tally; // slot holds a coarse tally
	logic is_tally;
	logic wr_hit;
	logic [22:0] masked;
	logic [23:0] next_word;
	logic [2:0] rd_slot;
	logic rd_hit;
	logic [23:0] store_q;
	logic rsp_valid;
	logic rsp_hit;

	// per-slot address, layout and selects; tallies sit at odd addresses
	for (genvar g = 0; g < trb_slots; g++)
	begin
		localparam logic [7:0] slot_addr = trb_first_addr + 8'(g);
		assign slot_tally[g] = slot_addr[0]; // RULE4 RULE5 RULE6
		assign rd_sel[g] = read_req.addr == slot_addr; // RULE9
		assign wr_sel[g] = result_in.valid && result_in.slot == 3'(g);
	end

	// fold one-hot selects; idle or unmapped reads use empty slot 7,
	// so the store itself hands back zero and data stays a flop output
	always_comb
	begin
		rd_slot = 3'h7;
		is_tally = 1'b0;
		for (int i = 0; i < trb_slots; i++)
		begin
			if (read_req.rd && rd_sel[i])
				rd_slot = 3'(i); // RULE8
			if (wr_sel[i])
				is_tally = slot_tally[i]; // RULE7
		end
	end
	// tallies keep only 16 bits; upper field forced to zero
	// since averaging mode is outside this block
	always_comb
	begin
		masked = result_in.value;
		if (is_tally)
			masked[trb_tally_hi:trb_tally_lo] = '0; // RULE7
	end
	// even parity: whole word xors to zero
	assign next_word = {^masked, masked}; // RULE10 RULE1 RULE2 RULE3 RULE9

	// only reads exist, no write path from the host
	assign rd_hit = |rd_sel; // RULE8
	assign wr_hit = |wr_sel;

	trb_word_store #(
		.depth(trb_slots),
		.width(trb_word_w)
	) u_store (
		.clk(clk),
		.rst(rst),
		.wr(wr_hit),
		.wr_idx(result_in.slot),
		.wr_data(next_word),
		.rd_idx(rd_slot),
		.rd_data(store_q)
	);

	// answer flags registered to line up with store data
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rsp_valid <= 1'b0;
			rsp_hit <= 1'b0;
		end
		else
		begin
			rsp_valid <= read_req.rd;
			rsp_hit <= read_req.rd && rd_hit;
		end
	end

	// unmapped or idle reads return zero straight from the store
	assign read_rsp = {rsp_valid, rsp_hit, store_q}; // RULE8
endmodule

// >>> trb_result_bank_properties.sv
// port assertions for the result bank
`timescale 1ns/100ps
module trb_chk
	import trb_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst, // reset
	input trb_pkg::trb_result_t result_in, // write
	input trb_pkg::trb_read_req_t read_req, // read
	input trb_pkg::trb_read_rsp_t read_rsp // answer
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// mapped window
	wire logic in_map = read_req.addr inside {[8'h12:8'h18]};
	// write slot 2, quiet cycle, then read its word
	sequence wr2_s;
		result_in.valid && result_in.slot == 3'h2 ##1 !result_in.valid
		##1 read_req.rd && read_req.addr == 8'h14 && !result_in.valid;
	endsequence
	answer_due_a: assert property (read_req.rd |=> read_rsp.valid)
		else $error("no answer");
	no_stray_a: assert property (!read_req.rd |=> !read_rsp.valid)
		else $error("stray answer");
	map_hit_a: assert property (read_req.rd && in_map |=> read_rsp.hit)
		else $error("missed word");
	miss_zero_a: assert property (read_req.rd && !in_map |=>
		read_rsp == 26'h2000000) else $error("bad miss");
	even_parity_a: assert property (read_rsp.valid |-> !(^read_rsp.data))
		else $error("odd parity");
	tally_top_a: assert property (read_req.rd && in_map && read_req.addr[0]
		|=> read_rsp.data[22:16] == 7'h00) else $error("tally high");
	read_back_a: assert property (wr2_s |=> read_rsp.data[22:0] ==
		$past(result_in.value, 3)) else $error("bad readback");
	reset_clear_a: assert property (disable iff (1'b0) rst |=>
		read_rsp == '0) else $error("reset leak");
endmodule
bind trb_result_bank trb_chk u_chk (.clk(clk), .rst(rst),
	.result_in(result_in), .read_req(read_req), .read_rsp(read_rsp));

// >>> trb_word_store.sv
// small memory of result words, registered read port
`timescale 1ns/100ps
module trb_word_store #(
	parameter int depth = 7,
	parameter int width = 24
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic wr, // write strobe
	input wire logic [2:0] wr_idx, // write slot
	input wire logic [width-1:0] wr_data, // write word
	input wire logic [2:0] rd_idx, // read slot
	output logic [width-1:0] rd_data // registered read word
);
	logic [width-1:0] mem [depth];

	// slot index is three bits wide; refuse depths it cannot reach
	if (depth < 1 || depth > 8 || width < 1)
	begin
		$error("trb_word_store depth or width out of range");
	end

	// every word cleared on reset so reads return zero until written
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < depth; i++)
		begin
			if (rst)
				mem[i] <= '0;
			else if (wr && wr_idx == 3'(i))
				mem[i] <= wr_data;
		end
	end

	// registered read; out-of-range slot reads zero
	always_ff @(posedge clk)
	begin
		if (rst)
			rd_data <= '0;
		else if (int'(rd_idx) < depth)
			rd_data <= mem[rd_idx];
		else
			rd_data <= '0;
	end
endmodule
